/* swuart_node.sv */
`timescale 1ns/1ps
`default_nettype none
module swuart_node
	import swuart_node_pkg::*;
(
	input  wire logic        REF_CLK,                    // System clock, 20 MHz
	input  wire logic        RESET_N,                    // Async reset, active low
	input  wire logic        SHARED_SERIAL_DATA_PIN_IN,  // Line level
	output logic             SHARED_SERIAL_DATA_PIN_OUT, // Line drive value
	output logic             SHARED_SERIAL_DATA_PIN_OE,  // High while driving
	input  wire logic        ADDRESS_SELECT_PLUS_FOUR,   // Adds 4
	input  wire logic        ADDRESS_SELECT_PLUS_TWO,    // Adds 2
	input  wire logic        ADDRESS_SELECT_PLUS_ONE,    // Adds 1
	input  wire logic [7:0]  PROGRAMMED_NODE_ADDRESS,    // Base node address
	input  wire logic [3:0]  REPLY_DELAY_SETTING,        // Steps of 8 bit times
	input  wire logic        CHAIN_SELECT_LOAD,          // Load chain select level
	input  wire logic        CHAIN_SELECT_VALUE,         // Level to load
	output logic             NEXT_NODE_ADDRESS_OUT,      // To next node's plus-one pin
	output logic             RD_REQ,                     // Read request pulse
	output logic [6:0]       RD_ADDR,                    // Register to read
	input  wire logic [31:0] RD_DATA,                    // Read data, taken at reply start
	output logic             WR_VALID,                   // Accepted write pulse
	output logic [6:0]       WR_ADDR,                    // Write register
	output logic [31:0]      WR_DATA,                    // Write data
	output logic [7:0]       DATAGRAM_COUNT,             // Accepted writes, wrapping
	output logic [11:0]      BIT_TIME                    // Measured bit time, cycles
);
	// ****************************************
	// State
	// ****************************************
	node_state_t r;
	node_state_t n;
	logic [7:0]  eff_addr;
	logic [7:0]  crc_stepped;
	logic        crc_bit;
	logic        fell;
	logic        rx_active;
	logic        rx_feed;
	logic [7:0]  tx_byte;
	logic [15:0] bit_reload;
	logic [19:0] gap_limit;
	logic [19:0] recover_len;
	logic [19:0] hold_len;
	logic [19:0] delay_len;
	logic [3:0]  delay_steps;

	assign eff_addr    = PROGRAMMED_NODE_ADDRESS + {5'h00, ADDRESS_SELECT_PLUS_FOUR,
		ADDRESS_SELECT_PLUS_TWO, ADDRESS_SELECT_PLUS_ONE};
	assign fell        = r.prev_in & ~SHARED_SERIAL_DATA_PIN_IN;
	assign tx_byte     = r.dbuf[63:56];
	assign bit_reload  = {4'h0, r.bit_time} - 16'h0001;
	assign gap_limit   = 20'(r.bit_time) * GAP_BITS;
	assign recover_len = 20'(r.bit_time) * RECOVER_BITS;
	assign hold_len    = 20'(r.bit_time) * HOLD_BITS;
	assign delay_steps = (REPLY_DELAY_SETTING == 4'h0) ? 4'h1 : REPLY_DELAY_SETTING;
	assign delay_len   = 20'(r.bit_time) * DELAY_STEP_BITS * 20'(delay_steps);
	assign rx_active   = (r.st == S_MEASURE) || (r.st == S_RX_BITS) || (r.st == S_RX_STOP) ||
		(r.st == S_WAIT_START) || (r.st == S_RX_START);
	// CRC byte itself is never fed: byte 3 of a read, byte 7 of a write
	assign rx_feed     = (r.byte_idx < READ_CRC_BYTE) || (r.wr_flag && r.byte_idx < WRITE_CRC_BYTE);
	assign crc_bit     = (r.st == S_TX) ? tx_byte[r.bit_idx[2:0]] : SHARED_SERIAL_DATA_PIN_IN;

	crc8_bit_step u_crc (
		.crc_in   (r.crc),
		.data_bit (crc_bit),
		.crc_out  (crc_stepped)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		n = r;
		n.rd_req = 1'b0;
		n.wr_valid = 1'b0;
		n.prev_in = SHARED_SERIAL_DATA_PIN_IN;
		if (CHAIN_SELECT_LOAD) begin
			n.chain = CHAIN_SELECT_VALUE;
		end
		if (rx_active) begin
			n.gap = r.gap + 20'h00001;
		end
		case (r.st)
			S_IDLE: begin
				n.oe = 1'b0;
				n.tx = 1'b1;
				if (fell) begin
					n.st = S_MEASURE;
					// Fall edge counts as cycle one, so four bits read as four bit times
					n.cnt = 16'h0001;
					n.edges = 1'b0;
					n.gap = 20'h00000;
				end
			end
			S_MEASURE: begin
				n.cnt = r.cnt + 16'h0001;
				if (r.cnt == 16'hFFFF) begin
					n.st = S_IDLE;
				end else if (fell) begin
					if (!r.edges) begin
						n.edges = 1'b1;
					end else if (r.cnt[15:14] != 2'b00 || r.cnt[13:2] < MIN_BIT_CYCLES) begin
						n.st = S_RECOVER;
						n.gap = recover_len;
					end else begin
						// Four bit times elapsed between the two falls
						n.bit_time = r.cnt[13:2];
						n.cnt = {5'h00, r.cnt[13:3]};
						n.st = S_RX_BITS;
						n.bit_idx = 4'h3;
						n.byte_idx = 4'h0;
						n.cur_byte = SYNC_PREFILL;
						n.crc = SYNC_CRC_SEED;
						n.wr_flag = 1'b0;
					end
				end
			end
			S_RX_BITS: begin
				if (r.cnt != 16'h0000) begin
					n.cnt = r.cnt - 16'h0001;
				end else begin
					n.cur_byte = {SHARED_SERIAL_DATA_PIN_IN, r.cur_byte[7:1]};
					if (rx_feed) begin
						n.crc = crc_stepped;
					end
					n.cnt = bit_reload;
					if (r.bit_idx == 4'h7) begin
						n.st = S_RX_STOP;
					end else begin
						n.bit_idx = r.bit_idx + 4'h1;
					end
				end
			end
			S_RX_STOP: begin
				if (r.cnt != 16'h0000) begin
					n.cnt = r.cnt - 16'h0001;
				end else if (!SHARED_SERIAL_DATA_PIN_IN) begin
					n.st = S_RECOVER;
					n.gap = recover_len;
				end else begin
					n.dbuf = {r.dbuf[55:0], r.cur_byte};
					n.byte_idx = r.byte_idx + 4'h1;
					n.st = S_WAIT_START;
					if (r.byte_idx == REG_ADDR_BYTE) begin
						n.wr_flag = r.cur_byte[7];
					end
					if (r.byte_idx == READ_CRC_BYTE && !r.wr_flag) begin
						if (r.crc != r.cur_byte) begin
							n.st = S_RECOVER;
							n.gap = recover_len;
						end else if (r.dbuf[15:8] == eff_addr && eff_addr != HOST_ADDRESS) begin
							n.rd_req = 1'b1;
							n.rd_addr = r.dbuf[6:0];
							n.st = S_DELAY;
							n.gap = delay_len - 20'h00001;
						end else begin
							n.st = S_IDLE;
						end
					end else if (r.byte_idx == WRITE_CRC_BYTE) begin
						if (r.crc != r.cur_byte) begin
							n.st = S_RECOVER;
							n.gap = recover_len;
						end else if (r.dbuf[47:40] == eff_addr && eff_addr != HOST_ADDRESS) begin
							n.wr_valid = 1'b1;
							n.wr_addr = r.dbuf[38:32];
							n.wr_data = r.dbuf[31:0];
							n.dgram_cnt = r.dgram_cnt + 8'h01;
							n.st = S_IDLE;
						end else begin
							n.st = S_IDLE;
						end
					end
				end
			end
			S_WAIT_START: begin
				if (fell) begin
					n.st = S_RX_START;
					n.cnt = {5'h00, r.bit_time[11:1]};
					n.gap = 20'h00000;
				end
			end
			S_RX_START: begin
				if (r.cnt != 16'h0000) begin
					n.cnt = r.cnt - 16'h0001;
				end else if (SHARED_SERIAL_DATA_PIN_IN) begin
					// Short pulse on the line: treat as error
					n.st = S_RECOVER;
					n.gap = recover_len;
				end else begin
					n.st = S_RX_BITS;
					n.cnt = bit_reload;
					n.bit_idx = 4'h0;
				end
			end
			S_RECOVER: begin
				if (!SHARED_SERIAL_DATA_PIN_IN) begin
					n.gap = recover_len;
				end else if (r.gap == 20'h00000) begin
					n.st = S_IDLE;
				end else begin
					n.gap = r.gap - 20'h00001;
				end
			end
			S_DELAY: begin
				if (r.gap != 20'h00000) begin
					n.gap = r.gap - 20'h00001;
				end else begin
					n.dbuf = {REPLY_SYNC_BYTE, REPLY_ADDRESS, 1'b0, r.rd_addr, RD_DATA, 8'h00};
					n.crc = 8'h00;
					n.st = S_TX;
					n.tx = 1'b0;
					n.oe = 1'b1;
					n.bit_idx = 4'h0;
					n.byte_idx = 4'h0;
					n.cnt = bit_reload;
				end
			end
			S_TX: begin
				if (r.cnt != 16'h0000) begin
					n.cnt = r.cnt - 16'h0001;
				end else begin
					n.cnt = bit_reload;
					if (r.bit_idx < 4'h8) begin
						n.tx = tx_byte[r.bit_idx[2:0]];
						if (r.byte_idx < WRITE_CRC_BYTE) begin
							n.crc = crc_stepped;
						end
						n.bit_idx = r.bit_idx + 4'h1;
					end else if (r.bit_idx == 4'h8) begin
						n.tx = 1'b1;
						n.bit_idx = 4'h9;
					end else if (r.byte_idx == WRITE_CRC_BYTE) begin
						n.st = S_TX_HOLD;
						n.gap = hold_len - 20'h00001;
					end else begin
						n.byte_idx = r.byte_idx + 4'h1;
						n.bit_idx = 4'h0;
						n.tx = 1'b0;
						// CRC is complete once the last data byte's stop bit runs
						n.dbuf = (r.byte_idx == TX_LAST_DATA) ? {r.crc, 56'h0} : {r.dbuf[55:0], 8'h00};
					end
				end
			end
			S_TX_HOLD: begin
				n.tx = 1'b1;
				if (r.gap != 20'h00000) begin
					n.gap = r.gap - 20'h00001;
				end else begin
					n.oe = 1'b0;
					n.st = S_IDLE;
				end
			end
			default: begin
				n.st = S_IDLE;
				n.oe = 1'b0;
			end
		endcase
		// Gap timeout overrides receive progress in every receive state except S_MEASURE
		if (rx_active && r.st != S_MEASURE && r.gap > gap_limit) begin
			n.st = S_RECOVER;
			n.gap = recover_len;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			r <= '0;
			r.st <= S_IDLE;
			r.bit_time <= BIT_TIME_RESET;
			r.prev_in <= 1'b1;
			r.chain <= 1'b1;
			r.tx <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign SHARED_SERIAL_DATA_PIN_OUT = r.tx;
	assign SHARED_SERIAL_DATA_PIN_OE  = r.oe;
	assign NEXT_NODE_ADDRESS_OUT      = r.chain;
	assign RD_REQ                     = r.rd_req;
	assign RD_ADDR                    = r.rd_addr;
	assign WR_VALID                   = r.wr_valid;
	assign WR_ADDR                    = r.wr_addr;
	assign WR_DATA                    = r.wr_data;
	assign DATAGRAM_COUNT             = r.dgram_cnt;
	assign BIT_TIME                   = r.bit_time;

	// ****************************************
	// Checks
	// ****************************************
	a_drive_only_reply: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		SHARED_SERIAL_DATA_PIN_OE |-> (r.st == S_TX || r.st == S_TX_HOLD || $past(r.st) == S_DELAY))
		else $error("Driver on outside reply");
	a_hold_drives_high: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		(r.st == S_TX_HOLD) |-> SHARED_SERIAL_DATA_PIN_OUT && SHARED_SERIAL_DATA_PIN_OE)
		else $error("Hold phase not driving high");
	a_release_after_hold: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		$fell(SHARED_SERIAL_DATA_PIN_OE) |-> $past(r.st) == S_TX_HOLD && $past(r.gap) == 20'h00000)
		else $error("Driver released early");
	a_start_bit_low: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		(r.st == S_TX && r.bit_idx == 4'h0) |-> !SHARED_SERIAL_DATA_PIN_OUT)
		else $error("Start bit not low");
	a_count_on_write: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		$changed(DATAGRAM_COUNT) |-> WR_VALID && DATAGRAM_COUNT == $past(DATAGRAM_COUNT) + 8'h01)
		else $error("Counter moved without write");
	a_read_goes_delay: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		RD_REQ |-> r.st == S_DELAY && r.gap == $past(delay_len) - 20'h00001)
		else $error("Read not followed by delay");
	a_never_host_addr: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		(RD_REQ || WR_VALID) |-> $past(eff_addr) != HOST_ADDRESS)
		else $error("Answered host address");
	a_bit_time_floor: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		$changed(BIT_TIME) |-> BIT_TIME >= MIN_BIT_CYCLES && $past(r.st) == S_MEASURE)
		else $error("Bad bit time update");
	a_chain_only_load: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		$changed(NEXT_NODE_ADDRESS_OUT) |-> $past(CHAIN_SELECT_LOAD))
		else $error("Chain output moved unasked");
	a_no_tx_on_badcrc: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		(r.st == S_RX_STOP && r.cnt == 16'h0000 && SHARED_SERIAL_DATA_PIN_IN && r.crc != r.cur_byte &&
		(r.byte_idx == WRITE_CRC_BYTE || (r.byte_idx == READ_CRC_BYTE && !r.wr_flag)))
		|=> !RD_REQ && !WR_VALID && r.st == S_RECOVER)
		else $error("Bad CRC datagram acted on");
endmodule
`default_nettype wire

/* swuart_node_pkg.sv */
// Notes on behaviour
// - Read request: sync 1010, reserved nibble, node address, register address, CRC byte.
// - Reply is sent with the bit time measured from the request.
// - Reply waits eight bit times per delay step; setting zero acts as one step.
// - Reply: sync 1010 with zero reserved bits, address 0xFF, register, data MSB first, CRC.
// - Line driver is released four bit times after the reply's last stop bit.
// - All-ones address belongs to the host; a node never answers to it.
// - CRC-8, polynomial 0x07, start zero, each byte LSB first, all bytes before CRC.
// - Only datagrams with good CRC and our own node address are acted on.
// - Datagram counter wraps at eight bits and counts each accepted write.
// - Pin stays input while idle; driver enabled only during a read reply.
// - Address select pins add four, two and one to the node address.
// - Next-address output comes out of reset high.
// - Eight-bit address arithmetic lets up to 255 chained nodes share one line.
// - Register address bit 7 is zero for read and one for write.
// - Bit time is measured from start bit fall to the fall between sync bits 2 and 3.
// - Effective address is programmed node address plus the pin offset.
// - Gap over 63 bit times between start bits resets; 12 idle bit times needed.
`default_nettype none
package swuart_node_pkg;
	localparam logic [7:0]  CRC_POLY         = 8'h07;
	localparam logic [7:0]  SYNC_CRC_SEED    = 8'h1B;
	localparam logic [7:0]  SYNC_PREFILL     = 8'hA0;
	localparam logic [7:0]  REPLY_SYNC_BYTE  = 8'h05;
	localparam logic [7:0]  REPLY_ADDRESS    = 8'hFF;
	localparam logic [7:0]  HOST_ADDRESS     = 8'hFF;
	localparam logic [11:0] MIN_BIT_CYCLES   = 12'h010;
	localparam logic [11:0] BIT_TIME_RESET   = 12'h010;
	localparam logic [19:0] GAP_BITS         = 20'h0003F;
	localparam logic [19:0] RECOVER_BITS     = 20'h0000C;
	localparam logic [19:0] HOLD_BITS        = 20'h00004;
	localparam logic [19:0] DELAY_STEP_BITS  = 20'h00008;
	localparam logic [3:0]  READ_CRC_BYTE    = 4'h3;
	localparam logic [3:0]  WRITE_CRC_BYTE   = 4'h7;
	localparam logic [3:0]  REG_ADDR_BYTE    = 4'h2;
	localparam logic [3:0]  TX_LAST_DATA     = 4'h6;

	typedef enum logic [3:0] {
		S_IDLE, S_MEASURE, S_RX_BITS, S_RX_STOP, S_WAIT_START,
		S_RX_START, S_RECOVER, S_DELAY, S_TX, S_TX_HOLD
	} state_t;

	typedef struct packed {
		state_t      st;
		logic [15:0] cnt;
		logic [11:0] bit_time;
		logic [3:0]  bit_idx;
		logic [3:0]  byte_idx;
		logic [63:0] dbuf;
		logic [7:0]  cur_byte;
		logic [7:0]  crc;
		logic [19:0] gap;
		logic        wr_flag;
		logic        prev_in;
		logic        edges;
		logic [7:0]  dgram_cnt;
		logic        chain;
		logic        tx;
		logic        oe;
		logic        rd_req;
		logic [6:0]  rd_addr;
		logic        wr_valid;
		logic [6:0]  wr_addr;
		logic [31:0] wr_data;
	} node_state_t;
endpackage
`default_nettype wire

/* crc8_bit_step.sv */
`timescale 1ns/1ps
`default_nettype none
module crc8_bit_step
	import swuart_node_pkg::*;
(
	input  wire logic [7:0] crc_in,   // Running CRC
	input  wire logic       data_bit, // Next serial bit
	output logic [7:0]      crc_out   // CRC after this bit
);
	assign crc_out = {crc_in[6:0], 1'b0} ^ ((crc_in[7] ^ data_bit) ? CRC_POLY : 8'h00);
endmodule
`default_nettype wire

/* swuart_node_dummy_end.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* host_uart_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_uart_model #(
	parameter int BT = 20
) (
	input  wire logic ref_clk, // System clock
	input  wire logic line,    // Resolved wire level
	output logic      drv      // Host drive, high when released
);
	initial drv = 1'b1;

	// ****************
	// CRC and framing
	// ****************
	function automatic logic [7:0] crc8(input logic [7:0] b [8], input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n; i++) begin
			for (int j = 0; j < 8; j++) begin
				c = (c[7] ^ b[i][j]) ? ((c << 1) ^ 8'h07) : (c << 1);
			end
		end
		return c;
	endfunction

	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			drv = f[i];
			repeat (BT) @(negedge ref_clk);
		end
	endtask

	// Sync byte first, then fields, then CRC (optionally corrupted)
	task automatic send_dgram(input logic [7:0] b [8], input int n, input logic bad);
		logic [7:0] c;
		c = crc8(b, n) ^ {7'h00, bad};
		@(negedge ref_clk);
		for (int i = 0; i < n; i++) begin
			send_byte(b[i]);
		end
		send_byte(c);
	endtask

	task automatic recv_byte(output logic [7:0] b, output logic ok);
		int k;
		k = 0;
		while (line === 1'b1 && k < 20000) begin
			@(posedge ref_clk);
			k++;
		end
		repeat (BT / 2) @(posedge ref_clk);
		ok = (line === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (BT) @(posedge ref_clk);
			b[i] = line;
		end
		repeat (BT) @(posedge ref_clk);
		ok = ok && (line === 1'b1);
	endtask
endmodule
`default_nettype wire

/* single_wire_uart_read_crc_addressing_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module single_wire_uart_read_crc_addressing_tb;
	import swuart_node_pkg::*;
	localparam int BT = 20;
	logic        ref_clk, reset_n, p4, p2, p1, ld, lv, drv;
	logic        out, oe, nxt, rd_req, wr_valid;
	logic [7:0]  node_addr, dcount;
	logic [3:0]  delay_set;
	logic [31:0] rd_data, wr_data;
	logic [6:0]  rd_addr, wr_addr;
	logic [11:0] bit_time;
	wire logic   line;
	int          error_cnt, num_checks, rd_cnt, wr_cnt;
	longint      t_req, t_up, t_dn;
	logic [7:0]  b [8];

	// Idle pull-up when nobody drives
	assign line = oe ? out : drv;

	swuart_node uut (.REF_CLK(ref_clk), .RESET_N(reset_n), .SHARED_SERIAL_DATA_PIN_IN(line),
		.SHARED_SERIAL_DATA_PIN_OUT(out), .SHARED_SERIAL_DATA_PIN_OE(oe),
		.ADDRESS_SELECT_PLUS_FOUR(p4), .ADDRESS_SELECT_PLUS_TWO(p2), .ADDRESS_SELECT_PLUS_ONE(p1),
		.PROGRAMMED_NODE_ADDRESS(node_addr), .REPLY_DELAY_SETTING(delay_set),
		.CHAIN_SELECT_LOAD(ld), .CHAIN_SELECT_VALUE(lv), .NEXT_NODE_ADDRESS_OUT(nxt),
		.RD_REQ(rd_req), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .WR_VALID(wr_valid),
		.WR_ADDR(wr_addr), .WR_DATA(wr_data), .DATAGRAM_COUNT(dcount), .BIT_TIME(bit_time));

	host_uart_model #(.BT(BT)) u_host (.ref_clk(ref_clk), .line(line), .drv(drv));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Pulses read mid-cycle; the launching edge lies half a period back
	always @(negedge ref_clk) begin
		if (rd_req === 1'b1) begin
			rd_cnt++;
			t_req = $time - 25;
		end
		if (wr_valid === 1'b1) wr_cnt++;
	end
	always @(posedge oe) t_up = $time;
	always @(negedge oe) t_dn = $time;

	// ****************
	// Shared helpers
	// ****************
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic set_read(input logic [7:0] a, input logic [6:0] r);
		b[0] = 8'h05;
		b[1] = a;
		b[2] = {1'b0, r};
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		check(oe, 1'b0, "oe after reset");
		check(out, 1'b1, "out after reset");
		check(nxt, 1'b1, "next address after reset");
		check(dcount, 8'h00, "count after reset");
		check(bit_time, 12'h010, "bit time after reset");
		$display("test reset done");
	endtask

	task automatic t_read(input logic [3:0] ds, input logic [31:0] d);
		logic [7:0] e [8];
		logic [7:0] got;
		logic ok;
		int rc, k, steps;
		@(negedge ref_clk);
		delay_set = ds;
		rd_data = d;
		rc = rd_cnt;
		steps = (ds == 4'h0) ? 1 : ds;
		set_read(8'h15, 7'h23);
		e = '{8'h05, 8'hFF, 8'h23, d[31:24], d[23:16], d[15:8], d[7:0], 8'h00};
		e[7] = u_host.crc8(e, 7);
		u_host.send_dgram(b, 3, 1'b0);
		for (int i = 0; i < 8; i++) begin
			u_host.recv_byte(got, ok);
			check(ok, 1'b1, "reply framing");
			check(got, e[i], "reply byte");
			if (!ok) report_and_stop();
		end
		k = 0;
		while (oe !== 1'b0 && k < 1000) begin
			@(posedge ref_clk);
			k++;
		end
		check(k < 1000, 1'b1, "driver released");
		check(rd_cnt - rc, 1, "read pulses");
		check(rd_addr, 7'h23, "read address");
		check(bit_time, 12'h014, "measured bit time");
		k = (t_up - t_req) / 50 - BT * 8 * steps;
		check(k >= 0 && k <= 2, 1'b1, "reply delay");
		k = (t_dn - t_up) / 50 - BT * 84;
		check(k >= 0 && k <= 2, 1'b1, "driver hold");
		repeat (2 * BT) @(negedge ref_clk);
		$display("test read done");
	endtask

	task automatic t_write(input logic bad);
		int wc;
		logic [7:0] c0;
		wc = wr_cnt;
		c0 = dcount;
		b = '{8'h05, 8'h15, 8'hA4, 8'h12, 8'h34, 8'h56, 8'h78, 8'h00};
		u_host.send_dgram(b, 7, bad);
		repeat (15 * BT) @(negedge ref_clk);
		check(wr_cnt - wc, bad ? 0 : 1, "write pulses");
		check(dcount, bad ? c0 : c0 + 8'h01, "datagram count");
		if (!bad) check({wr_addr, wr_data}, {7'h24, 32'h12345678}, "write fields");
		check(oe, 1'b0, "no drive on write");
		$display("test write done");
	endtask

	task automatic t_ignored(input logic [7:0] a, input logic bad);
		int rc;
		longint tu;
		rc = rd_cnt;
		tu = t_up;
		set_read(a, 7'h01);
		u_host.send_dgram(b, 3, bad);
		repeat (60 * BT) @(negedge ref_clk);
		check(rd_cnt - rc, 0, "ignored read pulses");
		check(t_up, tu, "ignored read reply");
		$display("test ignored done");
	endtask

	// Cut datagram must time out, else the next read is misframed
	task automatic t_gap;
		set_read(8'h15, 7'h23);
		u_host.send_byte(b[0]);
		u_host.send_byte(b[1]);
		repeat (70 * BT) @(negedge ref_clk);
		check(oe, 1'b0, "no drive after cut datagram");
		t_read(4'h2, 32'h0F1E2D3C);
		$display("test gap done");
	endtask

	task automatic t_chain;
		@(negedge ref_clk);
		ld = 1'b1;
		lv = 1'b0;
		@(negedge ref_clk);
		ld = 1'b0;
		check(nxt, 1'b0, "next address low");
		$display("test chain done");
	endtask

	initial begin
		reset_n = 1'b0;
		{p4, p2, p1, ld, lv} = 5'b10100;
		node_addr = 8'h10;
		delay_set = 4'h2;
		rd_data = 32'h0;
		error_cnt = 0;
		num_checks = 0;
		rd_cnt = 0;
		wr_cnt = 0;
		t_req = 0;
		t_up = 0;
		t_dn = 0;
		repeat (2) @(negedge ref_clk);
		reset_n = 1'b1;
		t_reset();
		repeat (4 * BT) @(negedge ref_clk);
		t_read(4'h2, 32'h89ABCDEF);
		t_gap();
		t_read(4'h0, 32'h00FF5AA5);
		t_write(1'b0);
		t_write(1'b1);
		t_ignored(8'h15, 1'b1);
		t_ignored(8'h16, 1'b0);
		@(negedge ref_clk);
		node_addr = 8'hF8;
		p2 = 1'b1;
		t_ignored(8'hFF, 1'b0);
		t_chain();
		report_and_stop();
	end
endmodule
`default_nettype wire
